/* File: logic/eeh_defines.svh */
// Purpose: timing counts, field positions and unlock constants for the eeprom host
// Assumes: 20 MHz mclk; 13-bit array address; 8-bit data
// Notes:   least times round up, longest times round down
`ifndef EEH_DEFINES_SVH
`define EEH_DEFINES_SVH

`define EEH_CLK_NS        50
// write pulse low and high least widths
`define EEH_T_WP_NS       200
`define EEH_T_WPH_NS      100
`define EEH_WP_CYC        ((`EEH_T_WP_NS + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
`define EEH_WPH_CYC       ((`EEH_T_WPH_NS + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
// least pulse that the device noise filter passes
`define EEH_T_GLITCH_NS   15
`define EEH_GLITCH_CYC    ((`EEH_T_GLITCH_NS + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
// read access, plus the data synchroniser depth
`define EEH_T_ACC_NS      200
`define EEH_ACC_CYC       ((`EEH_T_ACC_NS + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
`define EEH_SYNC_DEPTH    3
`define EEH_RD_LOW        (`EEH_ACC_CYC + `EEH_SYNC_DEPTH + 2)
`define EEH_RD_LAST       (`EEH_RD_LOW + 1)
`define EEH_WR_LAST       (`EEH_WP_CYC + `EEH_WPH_CYC)
// byte load window, longest time
`define EEH_T_BLC_NS      100000
`define EEH_BLC_CYC       (`EEH_T_BLC_NS / `EEH_CLK_NS)
// write cycle and power-up delay
`define EEH_T_WC_NS       10000000
`define EEH_T_PWR_NS      10000000
// address fields
`define EEH_PAGE_MSB      12
`define EEH_PAGE_LSB      6
`define EEH_BYTE_MSB      5
`define EEH_ID_BASE       13'h1FC0
// unlock command sequence, set these to the part in use
`define EEH_UNL_ADDR0     13'h0111
`define EEH_UNL_DATA0     8'h11
`define EEH_UNL_ADDR1     13'h0222
`define EEH_UNL_DATA1     8'h22
`define EEH_UNL_ADDR2     13'h0111
`define EEH_UNL_DATA2     8'h33

`endif

/* File: logic/eeh_pkg.sv */
// Purpose: types shared by the eeprom host
// Assumes: nothing
// Notes:   none
package eeh_pkg;
	typedef enum logic [2:0] {
		ST_PWRUP,
		ST_IDLE,
		ST_UNLK,
		ST_LOAD,
		ST_POLL,
		ST_READ
	} eeh_state_type;
endpackage

/* File: logic/eeh_pin_sync.sv */
// Purpose: three-stage synchroniser for the data pins
// Assumes: pins change asynchronously to mclk
// Notes:   a bit moves only once stages two and three agree
`timescale 1ns/1ns
module eeh_pin_sync (
	input  wire logic       mclk,    // system clock
	input  wire logic       rst,     // sync reset, high
	input  wire logic [7:0] pin_i,   // raw data pins
	output logic      [7:0] level_o  // filtered level
);
	logic [7:0] s1_reg;
	logic [7:0] s2_reg;
	logic [7:0] s3_reg;

	// stage one is read by stage two only
	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_reg  <= 8'h00;
			s2_reg  <= 8'h00;
			s3_reg  <= 8'h00;
			level_o <= 8'h00;
		end else begin
			s1_reg  <= pin_i;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			level_o <= (s2_reg & s3_reg) | (level_o & (s2_reg ^ s3_reg));
		end
	end
endmodule

/* File: logic/eeh_host.sv */
// Purpose: host controller driving a parallel page-write eeprom by its pins
// Assumes: one request at a time; write data held on wdata until taken
// Notes:   every write is unlocked, loaded back to back, then polled
//
// What this block does
// - Host starts a write by a strobe pulse, select low, output enable high.
// - A page load holds one to 64 bytes, programmed together.
// - Host presents each next byte within the byte load window.
// - Host keeps the page bits fixed on every strobe of one load.
// - Every write is preceded by a three-write unlock sequence.
`timescale 1ns/1ns
`include "eeh_defines.svh"
module eeh_host #(
	parameter int WC_CYC  = `EEH_T_WC_NS / `EEH_CLK_NS,  // write cycle limit
	parameter int PWR_CYC = `EEH_T_PWR_NS / `EEH_CLK_NS  // power-up hold-off
) (
	input  wire logic        mclk,        // 20 MHz clock
	input  wire logic        rst,         // sync reset, high
	input  wire logic        req_valid,   // request present
	input  wire logic        req_write,   // 1 page write, 0 read
	input  wire logic        req_id,      // target identification area
	input  wire logic [12:0] req_addr,    // first byte address
	input  wire logic [5:0]  req_len,     // bytes minus one
	input  wire logic [7:0]  wdata,       // write byte
	input  wire logic [7:0]  mem_dq_i,    // data pins in
	output logic             req_ready,   // idle, may take request
	output logic             wdata_take,  // write byte consumed
	output logic      [7:0]  rd_data,     // read result
	output logic             done,        // request finished
	output logic             err,         // poll timed out
	output logic      [12:0] mem_addr,    // address pins
	output logic             mem_ce_n,    // chip select, low
	output logic             mem_oe_n,    // output enable, low
	output logic             mem_we_n,    // write strobe, low
	output logic      [7:0]  mem_dq_o,    // data pins out
	output logic             mem_dq_oe,   // data pins driven
	output logic             id_hv_en     // raise id line to high voltage
);
	eeh_pkg::eeh_state_type state_reg;
	logic [3:0]  op_cnt_reg;
	logic [1:0]  unl_idx_reg;
	logic [5:0]  left_reg;
	logic [6:0]  page_reg;
	logic [5:0]  byte_reg;
	logic        id_reg;
	logic        last_b7_reg;
	logic        prev6_reg;
	logic        have_prev_reg;
	logic [7:0]  samp_reg;
	logic [23:0] tmr_reg;
	logic [7:0]  dq_sync;
	logic        is_wr;
	logic        op_end;
	logic        poll_ok;
	logic        tmo;
	logic        go_idle;

	// array address of a byte, folded into the id area when asked
	function automatic logic [12:0] cell_addr(input logic id, input logic [6:0] pg,
			input logic [5:0] bt);
		cell_addr = id ? (`EEH_ID_BASE | {7'h00, bt}) : {pg, bt};
	endfunction

	function automatic logic [12:0] unl_addr(input logic [1:0] idx);
		unl_addr = (idx == 2'h0) ? `EEH_UNL_ADDR0 :
			(idx == 2'h1) ? `EEH_UNL_ADDR1 : `EEH_UNL_ADDR2;
	endfunction

	function automatic logic [7:0] unl_data(input logic [1:0] idx);
		unl_data = (idx == 2'h0) ? `EEH_UNL_DATA0 :
			(idx == 2'h1) ? `EEH_UNL_DATA1 : `EEH_UNL_DATA2;
	endfunction

	eeh_pin_sync u_sync (
		.mclk    (mclk),
		.rst     (rst),
		.pin_i   (mem_dq_i),
		.level_o (dq_sync)
	);

	// op timing and exit conditions
	assign is_wr = (state_reg == eeh_pkg::ST_UNLK) || (state_reg == eeh_pkg::ST_LOAD);
	assign op_end = is_wr ? (op_cnt_reg == 4'(`EEH_WR_LAST)) : (op_cnt_reg == 4'(`EEH_RD_LAST));
	assign poll_ok = have_prev_reg && (samp_reg[7] == last_b7_reg) && (samp_reg[6] == prev6_reg);
	// no end seen within the write cycle
	assign tmo = tmr_reg >= 24'(WC_CYC);
	assign go_idle = ((state_reg == eeh_pkg::ST_PWRUP) && (tmr_reg >= 24'(PWR_CYC)))
		|| ((state_reg == eeh_pkg::ST_POLL) && op_end && (poll_ok || tmo))
		|| ((state_reg == eeh_pkg::ST_READ) && op_end);

	// sequencer
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= eeh_pkg::ST_PWRUP;
		end else begin
			unique case (state_reg)
				eeh_pkg::ST_PWRUP: if (go_idle) begin
					state_reg <= eeh_pkg::ST_IDLE;
				end
				eeh_pkg::ST_IDLE: if (req_valid) begin
					state_reg <= req_write ? eeh_pkg::ST_UNLK : eeh_pkg::ST_READ;
				end
				eeh_pkg::ST_UNLK: if (op_end && unl_idx_reg == 2'h2) begin
					state_reg <= eeh_pkg::ST_LOAD;
				end
				eeh_pkg::ST_LOAD: if (op_end && left_reg == 6'h00) begin
					state_reg <= eeh_pkg::ST_POLL;
				end
				eeh_pkg::ST_POLL: if (go_idle) begin
					state_reg <= eeh_pkg::ST_IDLE;
				end
				eeh_pkg::ST_READ: if (go_idle) begin
					state_reg <= eeh_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// op counter restarts each pin operation
	always_ff @(posedge mclk) begin
		if (rst || state_reg == eeh_pkg::ST_IDLE || state_reg == eeh_pkg::ST_PWRUP || op_end) begin
			op_cnt_reg <= 4'h0;
		end else begin
			op_cnt_reg <= op_cnt_reg + 4'h1;
		end
	end

	// power-up hold-off and write cycle timer
	always_ff @(posedge mclk) begin
		if (rst || state_reg == eeh_pkg::ST_IDLE) begin
			tmr_reg <= 24'h000000;
		end else if (state_reg == eeh_pkg::ST_PWRUP || state_reg == eeh_pkg::ST_POLL) begin
			tmr_reg <= tmr_reg + 24'h000001;
		end
	end

	// request capture and page walk
	always_ff @(posedge mclk) begin
		if (rst) begin
			unl_idx_reg <= 2'h0;
			left_reg    <= 6'h00;
			page_reg    <= 7'h00;
			byte_reg    <= 6'h00;
			id_reg      <= 1'b0;
			last_b7_reg <= 1'b0;
		end else if (state_reg == eeh_pkg::ST_IDLE) begin
			unl_idx_reg <= 2'h0;
			if (req_valid) begin
				left_reg <= req_len;
				page_reg <= req_addr[`EEH_PAGE_MSB:`EEH_PAGE_LSB];
				byte_reg <= req_addr[`EEH_BYTE_MSB:0];
				id_reg   <= req_id;
			end
		end else if (state_reg == eeh_pkg::ST_UNLK && op_end) begin
			unl_idx_reg <= unl_idx_reg + 2'h1;
		end else if (state_reg == eeh_pkg::ST_LOAD) begin
			if (op_cnt_reg == 4'h0) begin
				last_b7_reg <= wdata[7];
			end
			if (op_end && left_reg != 6'h00) begin
				left_reg <= left_reg - 6'h01;
				byte_reg <= byte_reg + 6'h01;
			end
		end
	end

	// poll sampling from the first read
	always_ff @(posedge mclk) begin
		if (rst || state_reg == eeh_pkg::ST_IDLE) begin
			samp_reg      <= 8'h00;
			prev6_reg     <= 1'b0;
			have_prev_reg <= 1'b0;
		end else if (!is_wr && state_reg != eeh_pkg::ST_PWRUP) begin
			if (op_cnt_reg == 4'(`EEH_RD_LOW)) begin
				samp_reg <= dq_sync;
			end
			if (op_end) begin
				prev6_reg     <= samp_reg[6];
				have_prev_reg <= 1'b1;
			end
		end
	end

	// pin drive; all pins registered
	always_ff @(posedge mclk) begin
		if (rst) begin
			mem_addr  <= 13'h0000;
			mem_ce_n  <= 1'b1;
			mem_oe_n  <= 1'b1;
			mem_we_n  <= 1'b1;
			mem_dq_o  <= 8'h00;
			mem_dq_oe <= 1'b0;
		end else if (is_wr) begin
			mem_ce_n  <= 1'b0;
			mem_oe_n  <= 1'b1;
			mem_dq_oe <= 1'b1;
			// strobe low for the full pulse width
			mem_we_n  <= !(op_cnt_reg >= 4'h1 && op_cnt_reg <= 4'(`EEH_WP_CYC));
			// address and data set before strobe, held after
			if (op_cnt_reg == 4'h0) begin
				// unlock writes carry command data only
				mem_addr <= (state_reg == eeh_pkg::ST_UNLK) ? unl_addr(unl_idx_reg)
					: cell_addr(id_reg, page_reg, byte_reg);
				mem_dq_o <= (state_reg == eeh_pkg::ST_UNLK) ? unl_data(unl_idx_reg) : wdata;
			end
		end else if (state_reg == eeh_pkg::ST_POLL || state_reg == eeh_pkg::ST_READ) begin
			// release the bus one cycle before output enable
			mem_ce_n  <= 1'b0;
			mem_we_n  <= 1'b1;
			mem_dq_oe <= 1'b0;
			mem_oe_n  <= !(op_cnt_reg >= 4'h1 && op_cnt_reg <= 4'(`EEH_RD_LOW));
			if (op_cnt_reg == 4'h0) begin
				mem_addr <= cell_addr(id_reg, page_reg, byte_reg);
			end
		end else begin
			mem_ce_n  <= 1'b1;
			mem_oe_n  <= 1'b1;
			mem_we_n  <= 1'b1;
			mem_dq_oe <= 1'b0;
		end
	end

	// id line raised for the whole id request
	always_ff @(posedge mclk) begin
		if (rst) begin
			id_hv_en <= 1'b0;
		end else begin
			id_hv_en <= id_reg && state_reg != eeh_pkg::ST_IDLE && state_reg != eeh_pkg::ST_PWRUP;
		end
	end

	// user side handshakes and results
	always_ff @(posedge mclk) begin
		if (rst) begin
			req_ready  <= 1'b0;
			wdata_take <= 1'b0;
			rd_data    <= 8'h00;
			done       <= 1'b0;
			err        <= 1'b0;
		end else begin
			req_ready  <= go_idle || (state_reg == eeh_pkg::ST_IDLE && !req_valid);
			// next byte requested at once, far inside the window
			wdata_take <= state_reg == eeh_pkg::ST_LOAD && op_cnt_reg == 4'h0;
			done       <= go_idle && state_reg != eeh_pkg::ST_PWRUP;
			if (state_reg == eeh_pkg::ST_READ && op_cnt_reg == 4'(`EEH_RD_LOW)) begin
				rd_data <= dq_sync;
			end
			if (go_idle && state_reg == eeh_pkg::ST_POLL) begin
				err <= !poll_ok;
			end
		end
	end

	// checking helpers: strobe falls since idle, cycles since last strobe fall, unlock or load
	logic [3:0]  wfall_reg;
	logic [11:0] gap_reg;
	always_ff @(posedge mclk) begin
		if (rst || state_reg == eeh_pkg::ST_IDLE) begin
			wfall_reg <= 4'h0;
			gap_reg   <= 12'h000;
		end else begin
			if (!mem_we_n && $past(mem_we_n) && wfall_reg != 4'hF) begin
				wfall_reg <= wfall_reg + 4'h1;
			end
			gap_reg <= (!mem_we_n && $past(mem_we_n)) ? 12'h000 : gap_reg + 12'h001;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	we_oe_excl_a: assert property (!mem_we_n |-> mem_oe_n && !mem_ce_n)
		else $error("write strobe low with output enable low");
	drive_read_a: assert property (mem_dq_oe |-> mem_oe_n)
		else $error("data driven while output enabled");
	pulse_width_a: assert property ($fell(mem_we_n) |-> !mem_we_n[*4])
		else $error("write pulse shorter than four cycles");
	unlock_first_a: assert property ($fell(mem_we_n) && state_reg == eeh_pkg::ST_LOAD
		|-> wfall_reg >= 4'h3)
		else $error("page load without unlock");
	page_fixed_a: assert property ($fell(mem_we_n) && state_reg == eeh_pkg::ST_LOAD && !id_reg
		|-> mem_addr[12:6] == page_reg)
		else $error("page bits changed during load");
	pwrup_block_a: assert property (state_reg == eeh_pkg::ST_PWRUP |-> mem_we_n && mem_ce_n)
		else $error("access during power-up delay");
	load_gap_a: assert property (state_reg == eeh_pkg::ST_LOAD |-> gap_reg < 12'(`EEH_BLC_CYC))
		else $error("byte load window exceeded");
	strobe_hold_a: assert property (!mem_we_n ##1 mem_we_n |-> $stable(mem_addr)
		&& $stable(mem_dq_o) && mem_dq_oe)
		else $error("address or data moved at strobe rise");
	poll_bound_a: assert property (state_reg == eeh_pkg::ST_POLL |-> tmr_reg <= 24'(WC_CYC)
		+ 24'(`EEH_RD_LAST))
		else $error("polling ran past the write cycle");

	read_done_c: cover property (state_reg == eeh_pkg::ST_READ ##1 done);
	write_done_c: cover property (state_reg == eeh_pkg::ST_POLL && go_idle && poll_ok);
	poll_tmo_c: cover property (state_reg == eeh_pkg::ST_POLL && go_idle && !poll_ok);
	id_write_c: cover property (id_hv_en && !mem_we_n);
endmodule

/* File: test/eeh_dev_model.sv */
// Purpose: behavioural page-write eeprom seen at the host pins
// Assumes: mclk only paces the load window and program timer
// Notes:   noise filter and power-up delay are not modelled
`timescale 1ns/1ns
`include "eeh_defines.svh"
module eeh_dev_model #(
	parameter int BLC_CYC = 40,  // load window, shortened
	parameter int WC_CYC  = 60,  // program time, shortened
	parameter int ACC_NS  = 150  // read access delay
) (
	input  wire logic        mclk,   // pacing clock
	input  wire logic [12:0] addr,   // address pins
	input  wire logic        ce_n,   // chip select
	input  wire logic        oe_n,   // output enable
	input  wire logic        we_n,   // write strobe
	input  wire logic [7:0]  dq_in,  // resolved data bus
	input  wire logic        id_hv,  // id line at high voltage
	input  wire logic        hang,   // hold programming open
	output logic      [7:0]  dq_out, // read drive value
	output logic             dq_en   // read drive enable
);
	logic [7:0]  arr [0:8191];
	logic [7:0]  idm [0:63];
	logic [7:0]  pbuf [0:63];
	logic [63:0] pmask;
	logic [12:0] wa;
	logic [12:0] last_a;
	logic [7:0]  last_d;
	logic [1:0]  ulk;
	logic        busy, loaded, tog, wid, armed;
	int          lcnt, pcnt;
	// inhibit unless selected, strobed, oe high
	wire         wr = ~ce_n & ~we_n & oe_n;
	function automatic logic [20:0] unl(input logic [1:0] i);
		case (i)
			2'h0: unl = {`EEH_UNL_ADDR0, `EEH_UNL_DATA0};
			2'h1: unl = {`EEH_UNL_ADDR1, `EEH_UNL_DATA1};
			default: unl = {`EEH_UNL_ADDR2, `EEH_UNL_DATA2};
		endcase
	endfunction
	initial begin
		for (int i = 0; i < 8192; i++)
			arr[i] = 8'hFF;
		for (int i = 0; i < 64; i++)
			idm[i] = 8'hFF;
		{pmask, ulk, busy, loaded, tog, wid, armed} = '0;
	end
	// address on later fall; armed so the unknown-to-low step at reset is no write
	always @(posedge wr) begin
		wa = addr;
		armed = 1'b1;
	end
	always @(negedge wr) begin
		if (!armed || busy) begin
		end else if (ulk == 2'h3) begin
			pbuf[wa[5:0]] = dq_in;
			pmask[wa[5:0]] = 1'b1;
			{loaded, lcnt, last_a, last_d, wid} = {1'b1, 32'h0, wa, dq_in, id_hv};
		end else if ({wa, dq_in} == unl(ulk)) begin
			ulk = ulk + 2'h1;
		end else begin
			{busy, pcnt, pmask, ulk, last_a, last_d} = {1'b1, 32'h0, 64'h0, 2'h0, wa, dq_in};
		end
		armed = 1'b0;
	end
	// load window, then timed program and relock
	always @(posedge mclk) begin
		if (loaded && !busy) begin
			lcnt++;
			if (lcnt >= BLC_CYC)
				{busy, loaded, pcnt} = {1'b1, 1'b0, 32'h0};
		end else if (busy) begin
			pcnt++;
			if (pcnt >= WC_CYC && !hang) begin
				for (int i = 0; i < 64; i++)
					if (pmask[i] && wid)
						idm[i] = pbuf[i];
					else if (pmask[i])
						arr[{last_a[12:6], i[5:0]}] = pbuf[i];
				{busy, ulk, pmask} = '0;
			end
		end
	end
	// a read ends the load; status bit flips per read
	always @(negedge oe_n)
		if (!ce_n && we_n) begin
			if (loaded)
				{busy, loaded, pcnt} = {1'b1, 1'b0, 32'h0};
			tog = ~tog;
		end
	// drive status while busy, else stored byte
	assign dq_en = ~ce_n & ~oe_n & we_n;
	assign #ACC_NS dq_out = busy ? {~last_d[7], tog, last_d[5:0]} :
		id_hv ? idm[addr[5:0]] : arr[addr];
endmodule

/* File: test/eeh_host_test.sv */
// Purpose: self-checking bench for the eeprom host
// Assumes: shortened program time and power-up hold-off
// Notes:   floating bus shows a pattern that flips every cycle
`timescale 1ns/1ns
module eeh_host_test;
	logic        mclk, rst, req_valid, req_write, req_id, hang;
	logic [12:0] req_addr, mem_addr;
	logic [5:0]  req_len;
	logic [7:0]  wdata, mem_dq_i, mem_dq_o, rd_data, dev_dq, float_v, got;
	logic        req_ready, wdata_take, done, err, got_err, dev_en;
	logic        mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe, id_hv_en;
	int          err_count, samples_checked, cyc, lat, takes;
	eeh_host #(.WC_CYC(200), .PWR_CYC(20)) dut (.mclk(mclk), .rst(rst),
		.req_valid(req_valid), .req_write(req_write), .req_id(req_id),
		.req_addr(req_addr), .req_len(req_len), .wdata(wdata), .mem_dq_i(mem_dq_i),
		.req_ready(req_ready), .wdata_take(wdata_take), .rd_data(rd_data),
		.done(done), .err(err), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n),
		.mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_dq_o(mem_dq_o),
		.mem_dq_oe(mem_dq_oe), .id_hv_en(id_hv_en));
	eeh_dev_model dev (.mclk(mclk), .addr(mem_addr), .ce_n(mem_ce_n), .oe_n(mem_oe_n),
		.we_n(mem_we_n), .dq_in(mem_dq_i), .id_hv(id_hv_en), .hang(hang),
		.dq_out(dev_dq), .dq_en(dev_en));
	// resolve the shared data bus
	assign mem_dq_i = mem_dq_oe ? mem_dq_o : dev_en ? dev_dq : float_v;
	always #25 mclk = ~mclk;
	// undriven bus pattern and hang limit
	always @(posedge mclk) begin
		float_v <= ~float_v;
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			close_out;
		end
	end
	task close_out;
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task chk_bit(input string n, input logic e, input logic g);
		chk_byte(n, {7'h00, e}, {7'h00, g});
	endtask
	task chk_cnt(input string n, input int e, input int g);
		samples_checked++;
		if (g != e) begin
			err_count++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	// one request; write byte k is b+k, wdata moves after each take
	task run_req(input logic w, input logic id, input logic [12:0] a,
		input logic [5:0] n, input logic [7:0] b);
		int k;
		k = 0;
		while (req_ready !== 1'b1)
			@(negedge mclk);
		@(posedge mclk);
		{req_write, req_id, req_addr, req_len} <= {w, id, a, n};
		wdata <= b;
		req_valid <= 1'b1;
		@(posedge mclk);
		req_valid <= 1'b0;
		lat = 0;
		do begin
			@(negedge mclk);
			lat++;
			if (wdata_take === 1'b1)
				k++;
			if (done !== 1'b1)
				@(posedge mclk) wdata <= b + k[7:0];
		end while (done !== 1'b1);
		takes = k;
		got = rd_data;
		got_err = err;
	endtask
	task rd_chk(input logic id, input logic [12:0] a, input logic [7:0] e);
		run_req(1'b0, id, a, 6'h00, 8'h00);
		chk_byte("rd_data", e, got);
		chk_cnt("read latency", 12, lat);
	endtask
	task wr_chk(input logic id, input logic [12:0] a, input logic [5:0] n,
		input logic [7:0] b, input logic e);
		run_req(1'b1, id, a, n, b);
		chk_bit("err", e, got_err);
		chk_cnt("wdata_take count", int'(n) + 1, takes);
	endtask
	task t_pwrup;
		repeat (19) begin
			@(negedge mclk);
			chk_bit("req_ready", 1'b0, req_ready);
			chk_bit("we_n", 1'b1, mem_we_n);
			chk_bit("ce_n", 1'b1, mem_ce_n);
		end
		repeat (3) @(negedge mclk);
		chk_bit("req_ready", 1'b1, req_ready);
	endtask
	task t_page;
		rd_chk(1'b0, 13'h0005, 8'hFF);
		wr_chk(1'b0, 13'h0050, 6'h3F, 8'h00, 1'b0);
		rd_chk(1'b0, 13'h0050, 8'h00);
		rd_chk(1'b0, 13'h007F, 8'h2F);
		rd_chk(1'b0, 13'h0040, 8'h30);
		rd_chk(1'b0, 13'h0080, 8'hFF);
	endtask
	task t_unlock;
		wr_chk(1'b0, 13'h0111, 6'h00, 8'h5A, 1'b0);
		wr_chk(1'b0, 13'h0222, 6'h00, 8'hC3, 1'b0);
		rd_chk(1'b0, 13'h0111, 8'h5A);
		rd_chk(1'b0, 13'h0222, 8'hC3);
	endtask
	task t_partial;
		wr_chk(1'b0, 13'h00C3, 6'h02, 8'h80, 1'b0);
		rd_chk(1'b0, 13'h00C2, 8'hFF);
		rd_chk(1'b0, 13'h00C5, 8'h82);
	endtask
	task t_ident;
		wr_chk(1'b1, 13'h0002, 6'h00, 8'h66, 1'b0);
		rd_chk(1'b1, 13'h0002, 8'h66);
		rd_chk(1'b0, 13'h1FC2, 8'hFF);
	endtask
	task t_hang;
		hang = 1'b1;
		wr_chk(1'b0, 13'h0200, 6'h00, 8'h77, 1'b1);
		hang = 1'b0;
		rd_chk(1'b0, 13'h0200, 8'h77);
	endtask
	initial begin
		{mclk, rst, req_valid, req_write, req_id, hang} = 6'b010000;
		{req_addr, req_len, wdata, float_v} = {13'h0000, 6'h00, 8'h00, 8'h5A};
		{err_count, samples_checked, cyc} = '0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_pwrup;
		t_page;
		t_unlock;
		t_partial;
		t_ident;
		t_hang;
		close_out;
	end
endmodule
